// ### common/fcl_pkg.sv
package fcl_pkg;

  // ****************************************
  // fuse and signature offsets
  // ****************************************
  localparam logic [7:0] OFS_WATCHDOG_CFG = 8'h00;
  localparam logic [7:0] OFS_BROWNOUT_CFG = 8'h01;
  localparam logic [7:0] OFS_OSC_CFG = 8'h02;
  localparam logic [7:0] OFS_TIMER_D_CFG = 8'h04;
  localparam logic [7:0] OFS_SYS_CFG_A = 8'h05;
  localparam logic [7:0] OFS_SYS_CFG_B = 8'h06;
  localparam logic [7:0] OFS_APP_END = 8'h07;
  localparam logic [7:0] OFS_BOOT_END = 8'h08;
  localparam logic [7:0] OFS_LOCK = 8'h0a;
  localparam logic [7:0] OFS_ERR_LOW_SUPPLY = 8'h24;
  localparam logic [7:0] OFS_ERR_HIGH_SUPPLY = 8'h25;

  // ****************************************
  // field positions
  // ****************************************
  localparam int WDT_WINDOW_LSB = 4;
  localparam int WDT_PERIOD_LSB = 0;
  localparam int BOD_LVL_LSB = 5;
  localparam int BOD_SAMP_BIT = 4;
  localparam int BOD_ACTIVE_LSB = 2;
  localparam int BOD_SLEEP_LSB = 0;
  localparam int OSC_LOCK_BIT = 7;
  localparam int OSC_FSEL_LSB = 0;
  localparam int TCD_EN_LSB = 4;
  localparam int TCD_DEF_LSB = 0;

  // ****************************************
  // codes and counts
  // ****************************************
  localparam logic [1:0] FSEL_16MHZ = 2'h1;
  localparam logic [1:0] FSEL_20MHZ = 2'h2;
  localparam logic [3:0] LOAD_CYCLES = 4'h5;
  localparam logic [7:0] RESET_BYTE = 8'h00;

  typedef struct packed {
    logic [3:0] window;
    logic [3:0] period;
  } fcl_wdt_s;

  typedef struct packed {
    logic [2:0] threshold;
    logic sample_rate;
    logic [1:0] active_mode;
    logic [1:0] sleep_mode;
  } fcl_bod_s;

  typedef struct packed {
    logic cal_lock;
    logic [1:0] freq_select;
    logic [7:0] freq_cal;
    logic [3:0] temp_cal;
  } fcl_osc_s;

  typedef struct packed {
    logic [3:0] pin_enable;
    logic [3:0] default_state;
  } fcl_tcd_s;

endpackage : fcl_pkg

// ### hdl/fcl_fuse_array.sv
`timescale 1ns/1ps
// ****************************************
// fuse storage: debug port writes, cpu reads only
// ****************************************
module fcl_fuse_array
  import fcl_pkg::*;
#(
  parameter int DEPTH = 16
) (
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic [7:0] rd_addr,
  output logic [7:0] rd_data,
  input wire logic dbg_wr,
  input wire logic [7:0] dbg_addr,
  input wire logic [7:0] dbg_wdata,
  input wire logic [7:0] ld_addr,
  output logic [7:0] ld_data
);
  logic [7:0] mem_ff [DEPTH];
  wire rd_hit = rd_addr < 8'(DEPTH);
  wire ld_hit = ld_addr < 8'(DEPTH);

  assign rd_data = rd_hit ? mem_ff[rd_addr[3:0]] : RESET_BYTE;
  assign ld_data = ld_hit ? mem_ff[ld_addr[3:0]] : RESET_BYTE;

  always_ff @(posedge clk) begin
    if (dbg_wr && dbg_addr < 8'(DEPTH)) begin
      mem_ff[dbg_addr[3:0]] <= dbg_wdata;
    end
  end

endmodule : fcl_fuse_array

// ### hdl/fcl_cal_table.sv
`timescale 1ns/1ps
// ****************************************
// factory calibration selection by frequency
// ****************************************
module fcl_cal_table
  import fcl_pkg::*;
(
  input wire logic [1:0] freq_select,
  input wire logic [7:0] cal16_freq,
  input wire logic [3:0] cal16_temp,
  input wire logic [7:0] cal20_freq,
  input wire logic [3:0] cal20_temp,
  output logic [7:0] freq_cal,
  output logic [3:0] temp_cal
);
  wire use20 = freq_select == FSEL_20MHZ;
  assign freq_cal = use20 ? cal20_freq : cal16_freq;
  assign temp_cal = use20 ? cal20_temp : cal16_temp;

endmodule : fcl_cal_table

// ### hdl/fcl_loader.sv
`timescale 1ns/1ps
module fcl_loader
  import fcl_pkg::*;
#(
  parameter int FUSE_DEPTH = 16
) (
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic por_flag,
  input wire logic [7:0] cpu_addr,
  input wire logic cpu_rd,
  input wire logic cpu_wr,
  output logic [7:0] cpu_rdata,
  output logic cpu_wr_denied,
  input wire logic dbg_rd,
  input wire logic dbg_wr,
  input wire logic [7:0] dbg_addr,
  input wire logic [7:0] dbg_wdata,
  output logic [7:0] dbg_rdata,
  input wire logic [7:0] err_low_supply,
  input wire logic [7:0] err_high_supply,
  input wire logic [7:0] cal16_freq,
  input wire logic [3:0] cal16_temp,
  input wire logic [7:0] cal20_freq,
  input wire logic [3:0] cal20_temp,
  input wire logic osc_cal_access,
  output logic osc_cal_refused,
  output fcl_wdt_s wdt_cfg,
  output fcl_bod_s bod_cfg,
  output fcl_osc_s osc_cfg,
  output fcl_tcd_s tcd_cfg,
  output logic periph_rst,
  output logic load_done
);

  // ****************************************
  // sequencer
  // ****************************************
  typedef enum logic [3:0] {
    ST_RESET = 4'b0001,
    ST_LOAD = 4'b0010,
    ST_APPLY = 4'b0100,
    ST_RUN = 4'b1000
  } fcl_state_e;

  fcl_state_e state_ff;
  fcl_state_e nxt_state;
  logic [3:0] cnt_ff;
  logic por_seen_ff;
  logic [7:0] ld_addr;
  logic [7:0] ld_data;
  logic [7:0] rd_addr;
  logic [7:0] arr_rdata;
  logic [7:0] wdt_b_ff, bod_b_ff, osc_b_ff, tcd_b_ff;
  fcl_wdt_s wdt_ff;
  fcl_bod_s bod_ff;
  fcl_osc_s osc_ff;
  fcl_tcd_s tcd_ff;
  logic [7:0] cpu_rdata_ff, dbg_rdata_ff;
  logic denied_ff, refused_ff, prst_ff, done_ff;
  logic [7:0] fcal;
  logic [3:0] tcal;

  always_comb begin
    nxt_state = state_ff;
    case (state_ff)
      ST_RESET: nxt_state = ST_LOAD;
      ST_LOAD: if (cnt_ff == LOAD_CYCLES - 4'h1) nxt_state = ST_APPLY;
      ST_APPLY: nxt_state = ST_RUN;
      ST_RUN: nxt_state = ST_RUN;
      default: nxt_state = ST_RESET;
    endcase
  end

  // fuse walk order: watchdog, brownout, oscillator, timer
  function automatic logic [7:0] walk_addr(input logic [3:0] idx);
    case (idx)
      4'h1: walk_addr = OFS_WATCHDOG_CFG;
      4'h2: walk_addr = OFS_BROWNOUT_CFG;
      4'h3: walk_addr = OFS_OSC_CFG;
      4'h4: walk_addr = OFS_TIMER_D_CFG;
      default: walk_addr = OFS_WATCHDOG_CFG;
    endcase
  endfunction : walk_addr

  assign ld_addr = walk_addr(cnt_ff);
  assign rd_addr = dbg_rd ? dbg_addr : cpu_addr;

  fcl_fuse_array #(
    .DEPTH(FUSE_DEPTH)
  ) u_fuses (
    .clk(clk),
    .sys_rst(sys_rst),
    .rd_addr(rd_addr),
    .rd_data(arr_rdata),
    .dbg_wr(dbg_wr),
    .dbg_addr(dbg_addr),
    .dbg_wdata(dbg_wdata),
    .ld_addr(ld_addr),
    .ld_data(ld_data)
  );

  fcl_cal_table u_cal (
    .freq_select(osc_b_ff[OSC_FSEL_LSB +: 2]),
    .cal16_freq(cal16_freq),
    .cal16_temp(cal16_temp),
    .cal20_freq(cal20_freq),
    .cal20_temp(cal20_temp),
    .freq_cal(fcal),
    .temp_cal(tcal)
  );

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      state_ff <= ST_RESET;
      cnt_ff <= 4'h0;
    end else begin
      state_ff <= nxt_state;
      cnt_ff <= (state_ff == ST_LOAD) ? cnt_ff + 4'h1 : 4'h0;
    end
  end

  // power-on kind is caught at reset release, not under reset value
  always_ff @(posedge clk) begin
    if (state_ff == ST_RESET) begin
      por_seen_ff <= por_flag;
    end
  end

  // ****************************************
  // staging of fuse bytes
  // ****************************************
  // bytes captured during start-up
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      wdt_b_ff <= RESET_BYTE;
      bod_b_ff <= RESET_BYTE;
      osc_b_ff <= RESET_BYTE;
      tcd_b_ff <= RESET_BYTE;
    end else if (state_ff == ST_LOAD) begin
      if (cnt_ff == 4'h1) wdt_b_ff <= ld_data;
      if (cnt_ff == 4'h2) bod_b_ff <= ld_data;
      if (cnt_ff == 4'h3) osc_b_ff <= ld_data;
      if (cnt_ff == 4'h4) tcd_b_ff <= ld_data;
    end
  end

  // ****************************************
  // target registers
  // ****************************************
  wire apply = state_ff == ST_APPLY;
  wire por_apply = apply && por_seen_ff;

  always_ff @(posedge clk) begin
    if (apply) begin
      wdt_ff.window <= wdt_b_ff[WDT_WINDOW_LSB +: 4];
      wdt_ff.period <= wdt_b_ff[WDT_PERIOD_LSB +: 4];
    end
  end

  always_ff @(posedge clk) begin
    if (por_apply) begin
      bod_ff.threshold <= bod_b_ff[BOD_LVL_LSB +: 3];
      bod_ff.sample_rate <= bod_b_ff[BOD_SAMP_BIT];
      bod_ff.active_mode <= bod_b_ff[BOD_ACTIVE_LSB +: 2];
      bod_ff.sleep_mode <= bod_b_ff[BOD_SLEEP_LSB +: 2];
    end
  end

  always_ff @(posedge clk) begin
    if (apply) begin
      osc_ff.cal_lock <= osc_b_ff[OSC_LOCK_BIT];
      osc_ff.freq_select <= osc_b_ff[OSC_FSEL_LSB +: 2];
      osc_ff.freq_cal <= fcal;
      osc_ff.temp_cal <= tcal;
    end
  end

  always_ff @(posedge clk) begin
    if (por_apply) begin
      tcd_ff.pin_enable <= tcd_b_ff[TCD_EN_LSB +: 4];
      tcd_ff.default_state <= tcd_b_ff[TCD_DEF_LSB +: 4];
    end
  end

  // ****************************************
  // read paths
  // ****************************************
  // low and high supply error bytes, fuse array byte otherwise
  function automatic logic [7:0] sel_read(input logic [7:0] a,
                                          input logic [7:0] arr,
                                          input logic [7:0] lo,
                                          input logic [7:0] hi);
    case (a)
      OFS_ERR_LOW_SUPPLY: sel_read = lo;
      OFS_ERR_HIGH_SUPPLY: sel_read = hi;
      default: sel_read = arr;
    endcase
  endfunction : sel_read

  // signature bytes passed in so the mux follows their changes
  wire [7:0] rd_sel = sel_read(rd_addr, arr_rdata, err_low_supply,
                               err_high_supply);

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      cpu_rdata_ff <= RESET_BYTE;
      dbg_rdata_ff <= RESET_BYTE;
      denied_ff <= 1'b0;
    end else begin
      if (cpu_rd && !dbg_rd) cpu_rdata_ff <= rd_sel;
      if (dbg_rd) dbg_rdata_ff <= rd_sel;
      denied_ff <= cpu_wr;
    end
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      refused_ff <= 1'b0;
      prst_ff <= 1'b1;
      done_ff <= 1'b0;
    end else begin
      refused_ff <= osc_cal_access && osc_ff.cal_lock
                    && state_ff == ST_RUN;
      prst_ff <= state_ff != ST_RUN;
      done_ff <= state_ff == ST_RUN;
    end
  end

  assign wdt_cfg = wdt_ff;
  assign bod_cfg = bod_ff;
  assign osc_cfg = osc_ff;
  assign tcd_cfg = tcd_ff;
  assign cpu_rdata = cpu_rdata_ff;
  assign dbg_rdata = dbg_rdata_ff;
  assign cpu_wr_denied = denied_ff;
  assign osc_cal_refused = refused_ff;
  assign periph_rst = prst_ff;
  assign load_done = done_ff;

  // ****************************************
  // checks
  // ****************************************
  wdt_copy_a: assert property (@(posedge clk) disable iff (sys_rst)
    apply |=> wdt_cfg.window == $past(wdt_b_ff[7:4]))
    else $error("watchdog window not loaded");
  wdt_period_a: assert property (@(posedge clk) disable iff (sys_rst)
    apply |=> wdt_cfg.period == $past(wdt_b_ff[3:0]))
    else $error("watchdog period not loaded");
  bod_keep_a: assert property (@(posedge clk) disable iff (sys_rst)
    (apply && !por_seen_ff) |=> $stable(bod_cfg))
    else $error("brownout changed on warm reset");
  bod_lvl_a: assert property (@(posedge clk) disable iff (sys_rst)
    por_apply |=> bod_cfg.threshold == $past(bod_b_ff[7:5]))
    else $error("brownout threshold wrong");
  tcd_keep_a: assert property (@(posedge clk) disable iff (sys_rst)
    (apply && !por_seen_ff) |=> $stable(tcd_cfg))
    else $error("timer settings changed on warm reset");
  osc_lock_a: assert property (@(posedge clk) disable iff (sys_rst)
    (osc_cal_access && osc_cfg.cal_lock && state_ff == ST_RUN)
    |=> osc_cal_refused)
    else $error("locked calibration not refused");
  load_time_a: assert property (@(posedge clk)
    $fell(sys_rst) |-> ##[7:8] load_done)
    else $error("load not done in time");
  hold_rst_a: assert property (@(posedge clk) disable iff (sys_rst)
    !load_done |-> periph_rst)
    else $error("peripherals released early");
  cpu_deny_a: assert property (@(posedge clk) disable iff (sys_rst)
    cpu_wr |=> cpu_wr_denied)
    else $error("cpu write not denied");
  err_read_a: assert property (@(posedge clk) disable iff (sys_rst)
    (cpu_rd && !dbg_rd && cpu_addr == OFS_ERR_LOW_SUPPLY)
    |=> cpu_rdata == $past(err_low_supply))
    else $error("low supply error byte wrong");
  err_high_a: assert property (@(posedge clk) disable iff (sys_rst)
    (dbg_rd && dbg_addr == OFS_ERR_HIGH_SUPPLY)
    |=> dbg_rdata == $past(err_high_supply))
    else $error("high supply error byte wrong");
  bod_rate_a: assert property (@(posedge clk) disable iff (sys_rst)
    por_apply |=> bod_cfg.sample_rate == $past(bod_b_ff[4]))
    else $error("brownout sample rate wrong");
  bod_act_a: assert property (@(posedge clk) disable iff (sys_rst)
    por_apply |=> bod_cfg.active_mode == $past(bod_b_ff[3:2]))
    else $error("brownout active mode wrong");
  bod_sleep_a: assert property (@(posedge clk) disable iff (sys_rst)
    por_apply |=> bod_cfg.sleep_mode == $past(bod_b_ff[1:0]))
    else $error("brownout sleep mode wrong");
  lock_copy_a: assert property (@(posedge clk) disable iff (sys_rst)
    apply |=> osc_cfg.cal_lock == $past(osc_b_ff[7]))
    else $error("calibration lock bit wrong");
  fsel_copy_a: assert property (@(posedge clk) disable iff (sys_rst)
    apply |=> osc_cfg.freq_select == $past(osc_b_ff[1:0]))
    else $error("frequency select wrong");
  cal20_a: assert property (@(posedge clk) disable iff (sys_rst)
    (apply && osc_b_ff[1:0] == FSEL_20MHZ) |=>
    osc_cfg.freq_cal == $past(cal20_freq)
    && osc_cfg.temp_cal == $past(cal20_temp))
    else $error("20 MHz calibration not written");
  cal16_a: assert property (@(posedge clk) disable iff (sys_rst)
    (apply && osc_b_ff[1:0] == FSEL_16MHZ) |=>
    osc_cfg.freq_cal == $past(cal16_freq)
    && osc_cfg.temp_cal == $past(cal16_temp))
    else $error("16 MHz calibration not written");
  tcd_pins_a: assert property (@(posedge clk) disable iff (sys_rst)
    por_apply |=> tcd_cfg.pin_enable == $past(tcd_b_ff[7:4]))
    else $error("compare pin enables wrong");
  tcd_fault_a: assert property (@(posedge clk) disable iff (sys_rst)
    por_apply |=> tcd_cfg.default_state == $past(tcd_b_ff[3:0]))
    else $error("compare default states wrong");
  fuse_hold_a: assert property (@(posedge clk) disable iff (sys_rst)
    (state_ff == ST_RUN) |=> $stable(wdt_cfg) && $stable(bod_cfg)
    && $stable(osc_cfg) && $stable(tcd_cfg))
    else $error("target changed outside load");

endmodule : fcl_loader

// ### sim/fcl_target_model.sv
`timescale 1ns/1ps
// ****************************************
// peripheral registers receiving the loaded watchdog, brownout and timer fuse values
// ****************************************
module fcl_target_model
  import fcl_pkg::*;
(
  input wire logic clk,
  input wire logic periph_rst,
  input wire fcl_wdt_s wdt_cfg,
  input wire fcl_bod_s bod_cfg,
  input wire fcl_tcd_s tcd_cfg,
  output logic [7:0] seen_wdt,
  output logic [7:0] seen_bod,
  output logic [7:0] seen_tcd
);
  logic rst_q_ff = 1'b1;

  always_ff @(posedge clk) begin
    rst_q_ff <= periph_rst;
    if (rst_q_ff && !periph_rst) begin
      seen_wdt <= wdt_cfg;
      seen_bod <= bod_cfg;
      seen_tcd <= tcd_cfg;
    end
  end
endmodule : fcl_target_model

// ### sim/test_fuse_config_loader.sv
`timescale 1ns/1ps
module test_fuse_config_loader
  import fcl_pkg::*;
;
  logic clk = 1'b0;
  logic sys_rst = 1'b1;
  logic por_flag = 1'b1;
  logic [7:0] cpu_addr = 8'h00;
  logic [7:0] dbg_addr = 8'h00;
  logic [7:0] dbg_wdata = 8'h00;
  logic cpu_rd = 1'b0;
  logic cpu_wr = 1'b0;
  logic dbg_rd = 1'b0;
  logic dbg_wr = 1'b0;
  logic osc_cal_access = 1'b0;
  logic [7:0] err_low_supply = 8'hf1;
  logic [7:0] err_high_supply = 8'h0e;
  logic [7:0] cal16_freq = 8'h3c;
  logic [7:0] cal20_freq = 8'hc3;
  logic [3:0] cal16_temp = 4'h9;
  logic [3:0] cal20_temp = 4'h6;
  logic [7:0] cpu_rdata;
  logic [7:0] dbg_rdata;
  logic cpu_wr_denied;
  logic osc_cal_refused;
  logic periph_rst;
  logic load_done;
  fcl_wdt_s wdt_cfg;
  fcl_bod_s bod_cfg;
  fcl_osc_s osc_cfg;
  fcl_tcd_s tcd_cfg;
  logic [7:0] seen_wdt;
  logic [7:0] seen_bod;
  logic [7:0] seen_tcd;
  logic [7:0] rd;
  int fail_count = 0;
  int check_count = 0;

  always #4 clk = ~clk;

  fcl_loader fcl_loader_i (.clk, .sys_rst, .por_flag, .cpu_addr, .cpu_rd,
    .cpu_wr, .cpu_rdata, .cpu_wr_denied, .dbg_rd, .dbg_wr, .dbg_addr,
    .dbg_wdata, .dbg_rdata, .err_low_supply, .err_high_supply, .cal16_freq,
    .cal16_temp, .cal20_freq, .cal20_temp, .osc_cal_access,
    .osc_cal_refused, .wdt_cfg, .bod_cfg, .osc_cfg, .tcd_cfg, .periph_rst,
    .load_done);

  fcl_target_model fcl_target_model_i (.clk, .periph_rst, .wdt_cfg,
    .bod_cfg, .tcd_cfg, .seen_wdt, .seen_bod, .seen_tcd);

  // ****************************************
  // shared tasks
  // ****************************************
  task automatic close_out;
    $display("checks %0d mismatches %0d", check_count, fail_count);
    if (fail_count == 0 && check_count > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask : close_out

  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    check_count++;
    if (got !== exp) begin
      fail_count++;
      $display("[ERR] %0t got %h expected %h", $time, got, exp);
    end
  endtask : chk

  task automatic prog(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk);
    dbg_wr <= 1'b1;
    dbg_addr <= a;
    dbg_wdata <= d;
    @(posedge clk);
    dbg_wr <= 1'b0;
  endtask : prog

  task automatic prog4(input logic [7:0] w, b, o, t);
    prog(OFS_WATCHDOG_CFG, w);
    prog(OFS_BROWNOUT_CFG, b);
    prog(OFS_OSC_CFG, o);
    prog(OFS_TIMER_D_CFG, t);
  endtask : prog4

  task automatic read_byte(input logic dbg, input logic [7:0] a);
    @(posedge clk);
    cpu_rd <= !dbg;
    dbg_rd <= dbg;
    cpu_addr <= a;
    dbg_addr <= a;
    @(posedge clk);
    cpu_rd <= 1'b0;
    dbg_rd <= 1'b0;
    #1 rd = dbg ? dbg_rdata : cpu_rdata;
  endtask : read_byte

  task automatic poke(input logic osc);
    @(posedge clk);
    osc_cal_access <= osc;
    cpu_wr <= !osc;
    cpu_addr <= OFS_WATCHDOG_CFG;
    @(posedge clk);
    osc_cal_access <= 1'b0;
    cpu_wr <= 1'b0;
    #1;
  endtask : poke

  task automatic do_reset(input logic por);
    @(posedge clk);
    sys_rst <= 1'b1;
    por_flag <= por;
    repeat (3) @(posedge clk);
    sys_rst <= 1'b0;
    @(posedge clk);
    #1 chk(16'(periph_rst), 16'h1);
    for (int i = 0; i < 20 && load_done !== 1'b1; i++) @(posedge clk);
    por_flag <= 1'b0;
    #1 chk(16'(periph_rst), 16'h0);
    chk(16'(load_done), 16'h1);
  endtask : do_reset

  task automatic chk_cfg(input logic [7:0] w, b, o, t);
    logic [7:0] fc;
    logic [3:0] tc;
    fc = (o[1:0] == FSEL_20MHZ) ? cal20_freq : cal16_freq;
    tc = (o[1:0] == FSEL_20MHZ) ? cal20_temp : cal16_temp;
    @(posedge clk);
    #1 chk(16'(wdt_cfg), 16'(w));
    chk(16'(bod_cfg), 16'(b));
    chk(16'(osc_cfg), 16'({o[7], o[1:0], fc, tc}));
    chk(16'(tcd_cfg), 16'(t));
    chk(16'({seen_wdt, seen_tcd}), {w, t});
    chk(16'(seen_bod), 16'(b));
  endtask : chk_cfg

  // ****************************************
  // test sequence
  // ****************************************
  initial begin
    // fuses written while the first load walks them, so no unknowns load
    fork
      prog4(8'ha5, 8'hb6, 8'h82, 8'h5c);
      begin
        repeat (3) @(posedge clk);
        sys_rst <= 1'b0;
      end
    join
    repeat (12) @(posedge clk);
    do_reset(1'b1);
    chk_cfg(8'ha5, 8'hb6, 8'h82, 8'h5c);
    poke(1'b1);
    chk(16'(osc_cal_refused), 16'h1);
    prog4(8'h3c, 8'h49, 8'h01, 8'hc3);
    chk(16'(wdt_cfg), 16'ha5);
    chk(16'(tcd_cfg), 16'h5c);
    do_reset(1'b0);
    chk_cfg(8'h3c, 8'hb6, 8'h01, 8'h5c);
    poke(1'b1);
    chk(16'(osc_cal_refused), 16'h0);
    read_byte(1'b0, OFS_ERR_LOW_SUPPLY);
    chk(16'(rd), 16'hf1);
    read_byte(1'b1, OFS_ERR_HIGH_SUPPLY);
    chk(16'(rd), 16'h0e);
    poke(1'b0);
    chk(16'(cpu_wr_denied), 16'h1);
    read_byte(1'b0, OFS_WATCHDOG_CFG);
    chk(16'(rd), 16'h3c);
    read_byte(1'b1, OFS_TIMER_D_CFG);
    chk(16'(rd), 16'hc3);
    prog(OFS_OSC_CFG, 8'h03);
    do_reset(1'b1);
    chk_cfg(8'h3c, 8'h49, 8'h03, 8'hc3);
    close_out;
  end

  initial begin
    repeat (5000) @(posedge clk);
    fail_count++;
    close_out;
  end
endmodule : test_fuse_config_loader
